// ==== rtl/bfsr_regs.sv ====
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - read-only fault register 02h, resets zero
// - bit 7 live open-string status
// - bit 6 live short-string status
// - bit 5 reference good status
// - bit 4 live boost output good
// - bit 3 overvoltage sticky, read clears
// - bit 2 overcurrent sticky, read clears
// - bit 1 thermal shutdown, outputs disabled
// - bit 0 undervoltage, operation disabled
// - string enable 16h, reset 3Fh
// - effective enable ANDs phase-shift enables
module bfsr_regs #(
  parameter int NSTR = bfsr_pkg::BFSR_NSTR
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire bfsr_pkg::bfsr_req_t req,
  output logic [bfsr_pkg::BFSR_DW-1:0] rdata_q,
  input wire bfsr_pkg::bfsr_det_t det,
  input wire logic [NSTR-1:0] phase_shift_mode,
  input wire logic [NSTR-1:0] dimming_pwm,
  output logic [NSTR-1:0] string_active,
  output logic [NSTR-1:0] led_drive,
  output logic outputs_disabled
);
  import bfsr_pkg::*;

  logic [BFSR_DW-1:0] force_q;
  logic [BFSR_DW-1:0] stren_q;
  logic [BFSR_DW-1:0] fault_view;
  logic fault_rd;
  logic ov_q;
  logic oc_q;

  assign fault_rd = req.rd && (req.addr == BFSR_OFF_FAULT);

  bfsr_sticky u_ov (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_i(det.overvoltage_event),
    .clr_i(fault_rd),
    .flag_q(ov_q)
  );

  bfsr_sticky u_oc (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_i(det.overcurrent_event),
    .clr_i(fault_rd),
    .flag_q(oc_q)
  );

  // live bits sampled straight from detectors
  always_comb begin
    fault_view = BFSR_RST_FAULT;
    fault_view[BFSR_BIT_OPEN] = det.led_open;
    fault_view[BFSR_BIT_SHORT] = det.led_short;
    fault_view[BFSR_BIT_REF] = det.ref_good;
    fault_view[BFSR_BIT_BOOST] = det.boost_output_good;
    fault_view[BFSR_BIT_OV] = ov_q;
    fault_view[BFSR_BIT_OC] = oc_q;
    fault_view[BFSR_BIT_TSD] = det.thermal_shutdown_flag;
    fault_view[BFSR_BIT_UV] = det.undervoltage_flag;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      force_q <= BFSR_RST_FORCE;
    end else if (req.wr && req.addr == BFSR_OFF_FORCE) begin
      force_q <= {{(BFSR_DW-NSTR){1'b0}}, req.wdata[NSTR-1:0]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stren_q <= BFSR_RST_STREN;
    end else if (req.wr && req.addr == BFSR_OFF_STREN) begin
      stren_q <= {{(BFSR_DW-NSTR){1'b0}}, req.wdata[NSTR-1:0]};
    end
  end

  // writes to the fault register are ignored; unmapped reads return zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (req.rd) begin
      case (req.addr)
        BFSR_OFF_FAULT: rdata_q <= fault_view;
        BFSR_OFF_FORCE: rdata_q <= force_q;
        BFSR_OFF_STREN: rdata_q <= stren_q;
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // thermal or supply fault blanks every string
  assign outputs_disabled = det.thermal_shutdown_flag | det.undervoltage_flag;

  genvar g;
  generate
    for (g = 0; g < NSTR; g++) begin : g_str
      assign string_active[g] = stren_q[g] & phase_shift_mode[g];
      assign led_drive[g] = string_active[g] & ~outputs_disabled &
                            (force_q[g] | dimming_pwm[g]);
    end
  endgenerate
endmodule // bfsr_regs
`default_nettype wire

// ==== rtl/bfsr_pkg.sv ====
package bfsr_pkg;
  localparam int BFSR_AW = 8;
  localparam int BFSR_DW = 8;
  localparam int BFSR_NSTR = 6;
  localparam logic [7:0] BFSR_OFF_FAULT = 8'h02;
  localparam logic [7:0] BFSR_OFF_FORCE = 8'h04;
  localparam logic [7:0] BFSR_OFF_STREN = 8'h16;
  localparam logic [7:0] BFSR_RST_FAULT = 8'h00;
  localparam logic [7:0] BFSR_RST_FORCE = 8'h00;
  localparam logic [7:0] BFSR_RST_STREN = 8'h3F;
  localparam int BFSR_BIT_OPEN = 7;
  localparam int BFSR_BIT_SHORT = 6;
  localparam int BFSR_BIT_REF = 5;
  localparam int BFSR_BIT_BOOST = 4;
  localparam int BFSR_BIT_OV = 3;
  localparam int BFSR_BIT_OC = 2;
  localparam int BFSR_BIT_TSD = 1;
  localparam int BFSR_BIT_UV = 0;

  typedef struct packed {
    logic led_open;
    logic led_short;
    logic ref_good;
    logic boost_output_good;
    logic overvoltage_event;
    logic overcurrent_event;
    logic thermal_shutdown_flag;
    logic undervoltage_flag;
  } bfsr_det_t;

  typedef struct packed {
    logic [BFSR_AW-1:0] addr;
    logic [BFSR_DW-1:0] wdata;
    logic wr;
    logic rd;
  } bfsr_req_t;
endpackage

// ==== rtl/bfsr_sticky.sv ====
`timescale 1ns/1ps
`default_nettype none
module bfsr_sticky (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_q
);
  // set wins over a read clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end
endmodule // bfsr_sticky
`default_nettype wire

// ==== bench/bfsr_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module bfsr_regs_checker #(parameter int NSTR = 6) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire bfsr_pkg::bfsr_req_t req,
  input wire logic [7:0] rdata_q,
  input wire bfsr_pkg::bfsr_det_t det,
  input wire logic [NSTR-1:0] phase_shift_mode,
  input wire logic [NSTR-1:0] dimming_pwm,
  input wire logic [NSTR-1:0] string_active,
  input wire logic [NSTR-1:0] led_drive,
  input wire logic outputs_disabled
);
  import bfsr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic f = req.rd && req.addr == BFSR_OFF_FAULT;
  // quiet event across both reads, so the first read alone must clear
  sequence s_clr(b);
    f && !b ##1 !b ##1 f && !b;
  endsequence
  a_live_view: assert property (f |=> rdata_q[7:4] == $past(det[7:4])) else $error("bad");
  a_ov_hold: assert property (det[3] ##1 f |=> rdata_q[3]) else $error("bad");
  a_ov_clr: assert property (s_clr(det[3]) |=> !rdata_q[3]) else $error("bad");
  a_oc_clr: assert property (s_clr(det[2]) |=> !rdata_q[2]) else $error("bad");
  a_and_en: assert property ((string_active & ~phase_shift_mode) == 0) else $error("bad");
  a_off_drive: assert property (outputs_disabled |-> led_drive == 0) else $error("bad");
  a_off_why: assert property (outputs_disabled == (det[1] | det[0])) else $error("bad");
  a_pwm_pass: assert property (outputs_disabled || (string_active & dimming_pwm & ~led_drive) == 0)
    else $error("bad");
endmodule // bfsr_regs_checker
bind bfsr_regs bfsr_regs_checker #(.NSTR(NSTR)) u_chk (.*);
`default_nettype wire

// ==== bench/backlight_fault_and_string_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module backlight_fault_and_string_regs_test;
  import bfsr_pkg::*;
  logic ref_clk = 0, rst = 1, outputs_disabled;
  bfsr_req_t req = '0;
  bfsr_det_t det = '0;
  logic [5:0] phase_shift_mode = 6'h2D, dimming_pwm = 6'h00, string_active, led_drive;
  logic [7:0] rdata_q;
  int n_fail = 0, samples_checked = 0;
  always #20 ref_clk = ~ref_clk;
  bfsr_regs DUT (.*);
  task chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t %h %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("%0d fails %0d checks", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reads carry the expected value as d; wdata is ignored then
  task op(input logic w, input logic [7:0] a, d);
    req <= '{a, d, w, !w};
    @(posedge ref_clk);
    if (!w) begin
      req <= '0;
      #1 chk(rdata_q, d);
      @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    op(0, 8'h02, 8'h00);
    op(0, 8'h04, 8'h00);
    op(0, 8'h16, 8'h3F);
    op(1, 8'h16, 8'hDF);
    op(1, 8'h04, 8'hC3);
    op(1, 8'h02, 8'hFF);
    op(0, 8'h55, 8'h00);
    op(0, 8'h16, 8'h1F);
    op(0, 8'h04, 8'h03);
    dimming_pwm <= 6'h3C;
    det <= 8'hF0;
    op(0, 8'h02, 8'hF0);
    chk({2'b00, string_active}, 8'h0D);
    chk({2'b00, led_drive}, 8'h0D);
    det <= 8'h0C;
    @(posedge ref_clk);
    det <= 8'h00;
    op(0, 8'h02, 8'h0C);
    op(0, 8'h02, 8'h00);
    det <= 8'h02;
    op(0, 8'h02, 8'h02);
    chk({2'b00, led_drive}, 8'h00);
    give_verdict;
  end
  initial begin
    #20us;
    n_fail++;
    give_verdict;
  end
endmodule // backlight_fault_and_string_regs_test
`default_nettype wire
